//--- pkg/midt_consts.svh
// constants for the instruction decode and cycle timing block
`ifndef MIDT_CONSTS_SVH
`define MIDT_CONSTS_SVH
`define MIDT_WORD_W        16
`define MIDT_FILE_W        8
`define MIDT_LIT_W         8
`define MIDT_ADDR_W        11
`define MIDT_OSC_PER_CYC   4
`define MIDT_TRAIL_NIB     4'hF
`define MIDT_NOP_WORD      16'h0000
`define MIDT_BIT_A         8
`define MIDT_BIT_D         9
`define MIDT_BIT_S         0
`define MIDT_BIT_FN_LO     4
`define MIDT_BIT_BN_LO     9
`define MIDT_MODE_MM_LO    0
`endif

//--- pkg/midt_pkg.sv
// types for the instruction decode and cycle timing block
package midt_pkg;
	typedef enum logic [1:0] {
		MIDT_CLS_BYTE,
		MIDT_CLS_BIT,
		MIDT_CLS_LIT,
		MIDT_CLS_CTRL
	} midt_class_t;

	typedef enum logic [1:0] {
		MIDT_TBL_NONE,
		MIDT_TBL_POSTINC,
		MIDT_TBL_POSTDEC,
		MIDT_TBL_PREINC
	} midt_tbl_t;

	typedef enum logic [1:0] {
		MIDT_ST_EXEC,
		MIDT_ST_WORD2,
		MIDT_ST_FLUSH
	} midt_state_t;
endpackage : midt_pkg

//--- core/midt_phase_gen.sv
// quadrature phase counter: four oscillator periods per instruction cycle
`timescale 1ns/1ns
`include "midt_consts.svh"
module midt_phase_gen
	import midt_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       clk_en,
	// phase outputs
	output logic [1:0]      phase_q,
	output logic            cyc_end_q
);
	logic [1:0] phase_d;
	logic       cyc_end_d;

	// wrap after the fourth oscillator period
	always_comb
	begin
		phase_d   = phase_q + 2'h1;
		cyc_end_d = (phase_d == 2'(`MIDT_OSC_PER_CYC - 1));
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			phase_q   <= 2'h0;
			cyc_end_q <= 1'b0;
		end
		else if (clk_en)
		begin
			phase_q   <= phase_d;
			cyc_end_q <= cyc_end_d;
		end
	end
endmodule : midt_phase_gen

//--- core/midt_decode.sv
// instruction field decoder and cycle sequencer for the 8-bit core
`timescale 1ns/1ns
`include "midt_consts.svh"
// Notes on behaviour
// - most instructions are one 16-bit word; some span two or three words
// - each word is classed as byte, bit, literal or control operation
// - destination bit zero writes working register, one writes file register
// - byte ops yield file address, destination bit and access bit
// - bit ops yield file address, bit number and access bit
// - literal ops yield literal and pointer number where present
// - control ops yield address, call/return mode and table mode where present
// - second word of a double-word instruction has top nibble all ones
// - a trailing word executed alone performs no operation
// - single word takes one cycle; skip or jump adds a no-op cycle
// - double-word instructions take two instruction cycles when no branch is taken
// - each instruction cycle is exactly four oscillator periods
// - a taken two-word branch takes three instruction cycles in total
// - access bit zero uses access RAM, one uses the bank select register
// - call/return mode zero leaves shadows alone, one saves or restores them
// - table mode picks no change, post-inc, post-dec or pre-inc
// - file address field is 8 bits, 00h to FFh
module midt_decode
	import midt_pkg::*;
#(
	parameter int WORD_W = `MIDT_WORD_W,
	parameter int ADDR_W = `MIDT_ADDR_W
)
(
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              clk_en,
	// fetch path
	input  wire logic [WORD_W-1:0] fetch_word,
	input  wire logic              fetch_is_lead2,
	input  wire logic              fetch_is_lead3,
	input  wire logic              fetch_cls_valid,
	input  wire logic [1:0]        fetch_cls,
	// datapath feedback
	input  wire logic              cond_true,
	input  wire logic              pc_changed,
	// decoded fields
	output midt_class_t            cls_q,
	output logic [7:0]             file_addr_q,
	output logic                   dest_file_q,
	output logic                   wr_working_register_q,
	output logic                   access_banked_q,
	output logic [2:0]             bit_num_q,
	output logic [7:0]             literal_q,
	output logic [1:0]             indirect_pointer_sel_q,
	output logic [ADDR_W-1:0]      prog_addr_q,
	output logic                   shadow_en_q,
	output midt_tbl_t              tbl_mode_q,
	// sequencing
	output logic                   exec_nop_q,
	output logic                   fetch_next_q,
	output logic                   instr_done_q,
	output logic [1:0]             phase_q,
	output logic [1:0]             cycles_used_q
);
	// field extraction shared by every class
	function automatic logic [7:0] midt_low8(input logic [WORD_W-1:0] w);
		return w[7:0];
	endfunction : midt_low8

	function automatic logic is_trailing(input logic [WORD_W-1:0] w);
		return w[WORD_W-1 -: 4] == `MIDT_TRAIL_NIB;
	endfunction : is_trailing

	logic cyc_end;

	// phase counter drives instruction cycle boundaries
	midt_phase_gen u_phase (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.clk_en    (clk_en),
		.phase_q   (phase_q),
		.cyc_end_q (cyc_end)
	);

	midt_state_t state_q;
	midt_state_t state_d;
	logic [1:0]  words_left_q;
	logic [1:0]  words_left_d;
	logic [1:0]  cycles_used_d;
	logic        exec_nop_d;
	logic        fetch_next_d;
	logic        instr_done_d;

	midt_class_t       cls_d;
	logic [7:0]        file_addr_d;
	logic              dest_file_d;
	logic              wr_working_register_d;
	logic              access_banked_d;
	logic [2:0]        bit_num_d;
	logic [7:0]        literal_d;
	logic [1:0]        indirect_pointer_sel_d;
	logic [ADDR_W-1:0] prog_addr_d;
	logic              shadow_en_d;
	midt_tbl_t         tbl_mode_d;

	// field decode; a lone trailing word is decoded like any other, the sequencer marks it a no-op
	always_comb
	begin
		cls_d                  = cls_q;
		file_addr_d            = file_addr_q;
		dest_file_d            = dest_file_q;
		wr_working_register_d  = wr_working_register_q;
		access_banked_d        = access_banked_q;
		bit_num_d              = bit_num_q;
		literal_d              = literal_q;
		indirect_pointer_sel_d = indirect_pointer_sel_q;
		prog_addr_d            = prog_addr_q;
		shadow_en_d            = shadow_en_q;
		tbl_mode_d             = tbl_mode_q;
		// only sample a fresh opcode at a cycle edge in the execute state
		if (cyc_end && state_q == MIDT_ST_EXEC && fetch_cls_valid)
		begin
			cls_d       = midt_class_t'(fetch_cls);
			file_addr_d = midt_low8(fetch_word);
			// access bit selects access RAM or banked RAM
			access_banked_d = fetch_word[`MIDT_BIT_A];
			dest_file_d     = 1'b0;
			bit_num_d       = 3'h0;
			literal_d       = 8'h00;
			indirect_pointer_sel_d = 2'h0;
			prog_addr_d     = '0;
			shadow_en_d     = 1'b0;
			tbl_mode_d      = MIDT_TBL_NONE;
			case (midt_class_t'(fetch_cls))
				MIDT_CLS_BYTE:
				begin
					dest_file_d = fetch_word[`MIDT_BIT_D];
				end
				MIDT_CLS_BIT:
				begin
					bit_num_d = fetch_word[`MIDT_BIT_BN_LO +: 3];
				end
				MIDT_CLS_LIT:
				begin
					literal_d = midt_low8(fetch_word);
					indirect_pointer_sel_d = fetch_word[`MIDT_BIT_FN_LO +: 2];
				end
				MIDT_CLS_CTRL:
				begin
					prog_addr_d = fetch_word[ADDR_W-1:0];
					shadow_en_d = fetch_word[`MIDT_BIT_S];
					tbl_mode_d  = midt_tbl_t'(fetch_word[`MIDT_MODE_MM_LO +: 2]);
				end
				default:
				begin
					cls_d = MIDT_CLS_CTRL;
				end
			endcase
			// destination steering for byte results
			wr_working_register_d = (midt_class_t'(fetch_cls) == MIDT_CLS_BYTE)
				&& !fetch_word[`MIDT_BIT_D];
		end
	end

	// cycle sequencer
	always_comb
	begin
		state_d       = state_q;
		words_left_d  = words_left_q;
		cycles_used_d = cycles_used_q;
		exec_nop_d    = exec_nop_q;
		fetch_next_d  = 1'b0;
		instr_done_d  = 1'b0;
		if (cyc_end)
		begin
			fetch_next_d = 1'b1;
			case (state_q)
				MIDT_ST_EXEC:
				begin
					// trailing word alone runs as a no-op
					exec_nop_d    = is_trailing(fetch_word);
					cycles_used_d = 2'h1;
					if (fetch_is_lead2 || fetch_is_lead3)
					begin
						// remaining words follow the lead word
						words_left_d = fetch_is_lead3 ? 2'h2 : 2'h1;
						state_d      = MIDT_ST_WORD2;
					end
					else if (cond_true || pc_changed)
					begin
						state_d       = MIDT_ST_FLUSH;
					end
					else
					begin
						instr_done_d = 1'b1;
					end
				end
				MIDT_ST_WORD2:
				begin
					// further words fetched while the lead executes
					exec_nop_d    = 1'b0;
					cycles_used_d = cycles_used_q + 2'h1;
					words_left_d  = words_left_q - 2'h1;
					if (words_left_q > 2'h1)
					begin
						state_d = MIDT_ST_WORD2;
					end
					else if (cond_true || pc_changed)
					begin
						state_d       = MIDT_ST_FLUSH;
					end
					else
					begin
						instr_done_d = 1'b1;
						state_d      = MIDT_ST_EXEC;
					end
				end
				MIDT_ST_FLUSH:
				begin
					// the prefetched word is discarded, a no-op runs instead
					exec_nop_d    = 1'b1;
					cycles_used_d = cycles_used_q + 2'h1;
					instr_done_d  = 1'b1;
					state_d       = MIDT_ST_EXEC;
				end
				default:
				begin
					state_d = MIDT_ST_EXEC;
				end
			endcase
		end
	end

	// one register bank; clk_en freezes everything
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_q                <= MIDT_ST_EXEC;
			words_left_q           <= 2'h0;
			cycles_used_q          <= 2'h0;
			exec_nop_q             <= 1'b1;
			fetch_next_q           <= 1'b0;
			instr_done_q           <= 1'b0;
			cls_q                  <= MIDT_CLS_CTRL;
			file_addr_q            <= 8'h00;
			dest_file_q            <= 1'b0;
			wr_working_register_q  <= 1'b0;
			access_banked_q        <= 1'b0;
			bit_num_q              <= 3'h0;
			literal_q              <= 8'h00;
			indirect_pointer_sel_q <= 2'h0;
			prog_addr_q            <= '0;
			shadow_en_q            <= 1'b0;
			tbl_mode_q             <= MIDT_TBL_NONE;
		end
		else if (clk_en)
		begin
			state_q                <= state_d;
			words_left_q           <= words_left_d;
			cycles_used_q          <= cycles_used_d;
			exec_nop_q             <= exec_nop_d;
			fetch_next_q           <= fetch_next_d;
			instr_done_q           <= instr_done_d;
			cls_q                  <= cls_d;
			file_addr_q            <= file_addr_d;
			dest_file_q            <= dest_file_d;
			wr_working_register_q  <= wr_working_register_d;
			access_banked_q        <= access_banked_d;
			bit_num_q              <= bit_num_d;
			literal_q              <= literal_d;
			indirect_pointer_sel_q <= indirect_pointer_sel_d;
			prog_addr_q            <= prog_addr_d;
			shadow_en_q            <= shadow_en_d;
			tbl_mode_q             <= tbl_mode_d;
		end
	end
endmodule : midt_decode

//--- tb/midt_decode_props.sv
// property checker for the decode and cycle timing block
`timescale 1ns/1ns
module midt_decode_props
	import midt_pkg::*;
(
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        clk_en,
	// watched outputs
	input wire midt_class_t cls_q,
	input wire logic [7:0]  file_addr_q,
	input wire logic        dest_file_q,
	input wire logic        wr_working_register_q,
	input wire logic        exec_nop_q,
	input wire logic        fetch_next_q,
	input wire logic        instr_done_q,
	input wire logic [1:0]  phase_q,
	input wire logic [1:0]  cycles_used_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// phase counts only on enabled edges
	phase_step_a: assert property (clk_en && !rst |=> phase_q == $past(phase_q) + 2'h1)
		else $error("phase did not advance");
	phase_hold_a: assert property (!clk_en |=> $stable(phase_q))
		else $error("phase moved while frozen");
	// cycle end follows the fourth period only
	cyc_end_a: assert property (fetch_next_q |-> phase_q == 2'h0 && $past(phase_q) == 2'h3)
		else $error("cycle end at wrong phase");
	fetch_gap_a: assert property (fetch_next_q |=> !fetch_next_q [*3])
		else $error("cycle ends too close");
	done_end_a: assert property (instr_done_q |-> fetch_next_q)
		else $error("done off a cycle end");
	dest_sel_a: assert property (wr_working_register_q == (cls_q == MIDT_CLS_BYTE && !dest_file_q))
		else $error("destination steering wrong");
	cyc_count_a: assert property (instr_done_q |-> cycles_used_q inside {2'h1, 2'h2, 2'h3})
		else $error("cycle count out of range");
	branch_nop_a: assert property (instr_done_q && cycles_used_q == 2'h3 |-> exec_nop_q)
		else $error("taken branch without no-op");
	// fields may only move at a cycle end
	field_hold_a: assert property (!fetch_next_q |-> $stable(file_addr_q) && $stable(cls_q))
		else $error("fields changed mid-cycle");
	cover property (instr_done_q && cycles_used_q == 2'h2);
	cover property (instr_done_q && cycles_used_q == 2'h3);
	cover property (!clk_en ##1 clk_en);
endmodule : midt_decode_props

bind midt_decode midt_decode_props props_u (.*);

//--- tb/midt_fetch_model.sv
// program fetch model: feeds words and datapath flags
`timescale 1ns/1ns
module midt_fetch_model
(
	// clock and reset
	input  wire logic  sys_clk,
	input  wire logic  rst,
	input  wire logic  fetch_next_q,
	// fetch side
	output logic [15:0] fetch_word,
	output logic        fetch_is_lead2,
	output logic        fetch_is_lead3,
	output logic        fetch_cls_valid,
	output logic [1:0]  fetch_cls,
	output logic        cond_true,
	output logic        pc_changed
);
	logic [22:0] rom [0:15];
	logic [3:0]  pc_q;
	// advance on every cycle end, so skipped words are still fetched
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			pc_q <= 4'h0;
		else
			pc_q <= pc_q + {3'h0, fetch_next_q};
	end
	// entry: cond, pc change, lead3, lead2, valid, class, word
	assign {cond_true, pc_changed, fetch_is_lead3, fetch_is_lead2,
		fetch_cls_valid, fetch_cls, fetch_word} = rom[pc_q];
endmodule : midt_fetch_model

//--- tb/midt_decode_tb.sv
// self-checking bench for the decode and cycle timing block
`timescale 1ns/1ns
`include "midt_consts.svh"
module midt_decode_tb;
	import midt_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic [15:0] w;
	logic l2, l3, v, ct, pcc, dest, wrw, acc, shd, nop, fn, done;
	logic [1:0] cl, ptr, ph, cyc;
	midt_class_t cls;
	midt_tbl_t tbl;
	logic [7:0] fa, lit;
	logic [2:0] bn;
	logic [10:0] pa;
	int err_total = 0;
	int tests_run = 0;
	int exp_cyc [12] = '{1, 1, 1, 1, 1, 1, 1, 1, 2, 3, 2, 1};
	int exp_nop [12] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 0, 1};
	logic [1:0] p;
	int gap;
	always #2 sys_clk = ~sys_clk;
	midt_decode dut_u (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .fetch_word(w),
		.fetch_is_lead2(l2), .fetch_is_lead3(l3), .fetch_cls_valid(v), .fetch_cls(cl),
		.cond_true(ct), .pc_changed(pcc), .cls_q(cls), .file_addr_q(fa), .dest_file_q(dest),
		.wr_working_register_q(wrw), .access_banked_q(acc), .bit_num_q(bn), .literal_q(lit),
		.indirect_pointer_sel_q(ptr), .prog_addr_q(pa), .shadow_en_q(shd), .tbl_mode_q(tbl),
		.exec_nop_q(nop), .fetch_next_q(fn), .instr_done_q(done), .phase_q(ph),
		.cycles_used_q(cyc));
	midt_fetch_model fm_u (.sys_clk(sys_clk), .rst(rst), .fetch_next_q(fn), .fetch_word(w),
		.fetch_is_lead2(l2), .fetch_is_lead3(l3), .fetch_cls_valid(v), .fetch_cls(cl),
		.cond_true(ct), .pc_changed(pcc));
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task summarize;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	// bounded wait for the end of an instruction
	task wait_done;
		int k;
		k = 0;
		@(posedge sys_clk);
		#1;
		while (done !== 1'b1 && k < 64)
		begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		gap = k;
		chk("done", {15'h0, done}, 16'h1);
	endtask : wait_done
	function logic [22:0] e(logic c, logic j, logic ld, logic [1:0] k, logic [15:0] x);
		return {c, j, 1'b0, ld, 1'b1, k, x};
	endfunction : e
	// watchdog: the program needs about a hundred clock cycles
	initial
	begin
		repeat (2000) @(posedge sys_clk);
		err_total++;
		summarize();
	end
	// program: classes, skip, two-word branch, lone trailing word
	initial
	begin
		fm_u.rom = '{e(0, 0, 0, 0, 16'h02A5), e(0, 0, 0, 0, 16'h01FF), e(0, 0, 0, 1, 16'h0B3C),
			e(0, 0, 0, 2, 16'h0E37), e(0, 0, 0, 3, 16'h0550), e(0, 0, 0, 3, 16'h0551),
			e(0, 0, 0, 3, 16'h0552), e(0, 0, 0, 3, 16'h0553), e(1, 0, 0, 0, 16'h0412),
			e(0, 0, 0, 0, 16'h0777), e(0, 1, 1, 3, 16'h0123), e(0, 1, 0, 3, 16'hF456),
			e(0, 0, 0, 0, 16'h0888), e(0, 0, 1, 3, 16'h0234), e(0, 0, 0, 3, 16'hF00F),
			e(0, 0, 0, 0, 16'hF123)};
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		for (int n = 0; n < 12; n++)
		begin
			wait_done();
			chk("cycles", cyc, exp_cyc[n]);
			// edges from one finished instruction to the next
			if (n > 0)
				chk("gap", gap, `MIDT_OSC_PER_CYC * exp_cyc[n] - 1);
			// later words must not overwrite the lead word's fields
			if (n == 9 || n == 10)
				chk("lead", pa, n == 9 ? 16'h0123 : 16'h0234);
			if (exp_nop[n] < 2)
				chk("nop", nop, exp_nop[n]);
			if (n < 2)
			begin
				chk("cls", cls, 16'h0);
				chk("dest", dest, 1 - n);
				chk("working_register", wrw, n);
				chk("bank", acc, n);
				chk("addr", fa, n ? 16'hFF : 16'hA5);
			end
			if (n == 2)
			begin
				chk("cls", cls, 16'h1);
				chk("bit", bn, 16'h5);
				chk("bank", acc, 16'h1);
				chk("addr", fa, 16'h3C);
			end
			if (n == 3)
			begin
				chk("cls", cls, 16'h2);
				chk("lit", lit, 16'h37);
				chk("ptr", ptr, 16'h3);
			end
			if (n > 3 && n < 8)
			begin
				chk("cls", cls, 16'h3);
				chk("tbl", tbl, n - 4);
				chk("shadow", shd, (n - 4) % 2);
				chk("paddr", pa, 16'h0550 + n - 4);
			end
		end
		// freeze: phase must hold with the enable low
		@(posedge sys_clk);
		clk_en <= 1'b0;
		@(posedge sys_clk);
		#1;
		p = ph;
		repeat (8) @(posedge sys_clk);
		#1;
		chk("freeze", ph, p);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk("resume", ph, 2'(p + 2'h1));
		repeat (4) @(posedge sys_clk);
		summarize();
	end
endmodule : midt_decode_tb
